// >>> hw/gpm_defines.svh
`ifndef GPM_DEFINES_SVH
`define GPM_DEFINES_SVH

// ==========================================
// Register byte offsets
`define GPM_OFF_SEL 8'h00
`define GPM_OFF_DATA 8'h04
`define GPM_OFF_DIR 8'h08
`define GPM_OFF_PAD 8'h0c
`define GPM_OFF_MUX 8'h10
`define GPM_OFF_LOCK 8'h14
`define GPM_OFF_COMMIT 8'h18
`define GPM_OFF_WAKE 8'h1c

// ==========================================
// Field positions inside the pad register
`define GPM_PAD_DRV_LSB 0
`define GPM_PAD_DRV_MSB 2
`define GPM_PAD_TYP_LSB 4
`define GPM_PAD_TYP_MSB 6

// ==========================================
// Constants and reset values
`define GPM_UNLOCK_KEY 32'h1acc_e55e
`define GPM_PROTECT_DEFAULT 8'h0f
`define GPM_GPIO_FUNC 0

`endif

// >>> hw/gpm_pkg.sv
package gpm_pkg;
   typedef enum logic [2:0] {
      drive_low,
      drive_medium,
      drive_high,
      drive_high_slew_limited,
      drive_extra_a,
      drive_extra_b,
      drive_extra_c
   } gpm_drive_t;

   typedef enum logic [2:0] {
      pad_push_pull,
      pad_push_pull_pullup,
      pad_push_pull_pulldown,
      pad_open_drain,
      pad_analog,
      pad_wake_high,
      pad_wake_low
   } gpm_pad_t;
endpackage

// >>> hw/gpm_pad.sv
`timescale 1ns/1ns
module gpm_pad
   import gpm_pkg::*;
(
   input wire logic gpio_out_i,
   input wire logic gpio_dir_i,
   input wire logic use_func_i,
   input wire logic func_out_i,
   input wire logic func_oe_i,
   input wire logic level_i,
   input wire gpm_pkg::gpm_drive_t drive_i,
   input wire gpm_pkg::gpm_pad_t type_i,
   output logic out_o,
   output logic oe_o,
   output logic pu_o,
   output logic pd_o,
   output logic [2:0] drive_o,
   output logic slew_o,
   output logic ana_o,
   output logic wake_o
);
   logic drv_en;
   logic val;

   always_comb begin
      drv_en = use_func_i ? func_oe_i : gpio_dir_i;
      val = use_func_i ? func_out_i : gpio_out_i;
      out_o = 1'b0;
      oe_o = 1'b0;
      pu_o = 1'b0;
      pd_o = 1'b0;
      ana_o = 1'b0;
      wake_o = 1'b0;
      unique case (type_i)
         pad_analog: begin
            ana_o = 1'b1;
         end
         pad_open_drain: begin
            // Never drives high; when released the pin floats, with no pull enabled
            oe_o = drv_en & ~val;
         end
         default: begin
            oe_o = drv_en;
            out_o = val;
            pu_o = (type_i == pad_push_pull_pullup);
            pd_o = (type_i == pad_push_pull_pulldown);
            wake_o = (type_i == pad_wake_high) ? level_i :
                     (type_i == pad_wake_low) ? ~level_i : 1'b0;
         end
      endcase
      // Strength only matters while driving; an input drops drive and slew but keeps its pulls, analog and wake settings
      drive_o = oe_o ? drive_i : drive_low;
      slew_o = oe_o & (drive_i == drive_high_slew_limited);
   end
endmodule

// >>> hw/gpm_port.sv
// The register offsets and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ns
`include "gpm_defines.svh"
// Functional notes
// - Eight-bit mask, bit 0 selects pin 0
// - Input pins store pads; pulls, analog and wake still apply
// - Drives of 2, 4, 8 mA, 8 mA slew
// - Optional extra drives of 6, 10, 12 mA
// - Push-pull, pull-up, pull-down, open-drain, analog
// - Optional wake source, high or low sense
// - At most one function per pin
// - Lowest-letter port wins duplicate signal mapping
// - Masked read returns levels of selected pins
// - Unselected pins and upper bits read zero
// - Protected pins need unlock and commit first

module gpm_port
   import gpm_pkg::*;
#(
   parameter int NPINS = 8,
   parameter int NFUNC = 8,
   parameter int MUXW = 3,
   parameter bit EXTRA_DRIVE = 1'b1,
   parameter bit WAKE_SUPPORT = 1'b1,
   parameter logic [7:0] PROTECT_MASK = `GPM_PROTECT_DEFAULT
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [NPINS-1:0] pad_in_i,
   output logic [NPINS-1:0] pad_out_o,
   output logic [NPINS-1:0] pad_oe_o,
   output logic [NPINS-1:0] pad_pu_o,
   output logic [NPINS-1:0] pad_pd_o,
   output logic [NPINS*3-1:0] pad_drive_o,
   output logic [NPINS-1:0] pad_slew_o,
   output logic [NPINS-1:0] pad_ana_o,
   output logic wake_o,
   input wire logic [NFUNC-1:0] func_out_i,
   input wire logic [NFUNC-1:0] func_oe_i,
   output logic [NFUNC-1:0] func_in_o,
   input wire logic [NFUNC-1:0] claim_in_i,
   output logic [NFUNC-1:0] claim_o
);
   import gpm_pkg::*;

   // ==========================================
   // Helpers
   // Lowest set bit; pin 0 when the mask is empty
   function automatic logic [2:0] first_pin(input logic [NPINS-1:0] mask);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = NPINS - 1; i >= 0; i--) begin
         if (mask[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction

   // Codes this variant lacks are refused rather than aliased
   function automatic logic drive_ok(input logic [2:0] code);
      logic ok;
      ok = 1'b0;
      if (code <= 3'(drive_high_slew_limited)) begin
         ok = 1'b1;
      end else if (code <= 3'(drive_extra_c)) begin
         ok = EXTRA_DRIVE;
      end
      return ok;
   endfunction

   // Wake types exist only where hibernation sensing is built
   function automatic logic type_ok(input logic [2:0] code);
      logic ok;
      ok = 1'b0;
      if (code <= 3'(pad_analog)) begin
         ok = 1'b1;
      end else if (code <= 3'(pad_wake_low)) begin
         ok = WAKE_SUPPORT;
      end
      return ok;
   endfunction

   // ==========================================
   // State
   logic [NPINS-1:0] sel_q;
   logic [NPINS-1:0] out_q;
   logic [NPINS-1:0] dir_q;
   // Pad settings are kept even while a pin is an input
   gpm_drive_t drive_q [NPINS];
   gpm_pad_t type_q [NPINS];
   logic [MUXW-1:0] mux_q [NPINS];
   logic lock_q;
   logic [NPINS-1:0] commit_q;
   logic ack_q;
   logic [31:0] dat_q;

   logic req;
   logic wr;
   logic [NPINS-1:0] cfg_ok;
   logic [2:0] first;
   logic [31:0] dat_d;

   // A held strobe is taken once; ack_q masks the repeat
   assign req = wb_cyc_i & wb_stb_i & ~ack_q;
   // Every field but the lock key sits in the low byte, so writes other than to the lock need lane 0
   assign wr = req & wb_we_i & wb_sel_i[0];
   assign first = first_pin(sel_q);
   // Locked pins ignore reconfiguration until unlocked and committed
   assign cfg_ok = sel_q & commit_q;

   // ==========================================
   // Wishbone handshake
   // Registered ack gives one wait state and a flopped read path
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   // Unmapped offsets read zero and are still acknowledged
   always_comb begin
      dat_d = 32'h0;
      unique case (wb_adr_i)
         `GPM_OFF_SEL: dat_d[NPINS-1:0] = sel_q;
         `GPM_OFF_DATA: dat_d[NPINS-1:0] = pad_in_i & sel_q;
         `GPM_OFF_DIR: dat_d[NPINS-1:0] = dir_q;
         `GPM_OFF_PAD: begin
            dat_d[`GPM_PAD_DRV_MSB:`GPM_PAD_DRV_LSB] = drive_q[first];
            dat_d[`GPM_PAD_TYP_MSB:`GPM_PAD_TYP_LSB] = type_q[first];
         end
         `GPM_OFF_MUX: dat_d[MUXW-1:0] = mux_q[first];
         `GPM_OFF_LOCK: dat_d[0] = lock_q;
         `GPM_OFF_COMMIT: dat_d[NPINS-1:0] = commit_q;
         `GPM_OFF_WAKE: dat_d[0] = wake_o;
         default: dat_d = 32'h0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= 32'h0;
      end else if (req) begin
         dat_q <= dat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // ==========================================
   // Selection, data and direction
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_q <= '0;
      end else if (wr && wb_adr_i == `GPM_OFF_SEL) begin
         // Never locked: the mask only addresses pins
         sel_q <= wb_dat_i[NPINS-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_q <= '0;
      end else if (wr && wb_adr_i == `GPM_OFF_DATA) begin
         // Writing levels is not reconfiguration, so the lock does not gate it
         out_q <= (out_q & ~sel_q) | (wb_dat_i[NPINS-1:0] & sel_q);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dir_q <= '0;
      end else if (wr && wb_adr_i == `GPM_OFF_DIR) begin
         // Direction is reconfiguration: committed pins only
         dir_q <= (dir_q & ~cfg_ok) | (wb_dat_i[NPINS-1:0] & cfg_ok);
      end
   end

   // ==========================================
   // Pad configuration and function mux
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int p = 0; p < NPINS; p++) begin
            drive_q[p] <= drive_low;
            type_q[p] <= pad_push_pull;
         end
      end else if (wr && wb_adr_i == `GPM_OFF_PAD) begin
         for (int p = 0; p < NPINS; p++) begin
            // Codes absent on this variant are dropped, old value kept
            if (cfg_ok[p] && drive_ok(wb_dat_i[`GPM_PAD_DRV_MSB:`GPM_PAD_DRV_LSB])) begin
               drive_q[p] <= gpm_drive_t'(wb_dat_i[`GPM_PAD_DRV_MSB:`GPM_PAD_DRV_LSB]);
            end
            if (cfg_ok[p] && type_ok(wb_dat_i[`GPM_PAD_TYP_MSB:`GPM_PAD_TYP_LSB])) begin
               type_q[p] <= gpm_pad_t'(wb_dat_i[`GPM_PAD_TYP_MSB:`GPM_PAD_TYP_LSB]);
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int p = 0; p < NPINS; p++) begin
            mux_q[p] <= MUXW'(`GPM_GPIO_FUNC);
         end
      end else if (wr && wb_adr_i == `GPM_OFF_MUX) begin
         for (int p = 0; p < NPINS; p++) begin
            // One field per pin: a pin can hold only one function
            if (cfg_ok[p]) begin
               mux_q[p] <= wb_dat_i[MUXW-1:0];
            end
         end
      end
   end

   // ==========================================
   // Lock and commit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_q <= 1'b1;
      end else if (req && wb_we_i && wb_adr_i == `GPM_OFF_LOCK) begin
         // Full-word key only; any other write relocks
         // Unlocking opens the commit register only, never the pins
         lock_q <= !(wb_sel_i == 4'hf && wb_dat_i == `GPM_UNLOCK_KEY);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         commit_q <= ~PROTECT_MASK;
      end else if (wr && !lock_q && wb_adr_i == `GPM_OFF_COMMIT) begin
         // Unprotected pins stay committed whatever is written
         commit_q <= wb_dat_i[NPINS-1:0] | ~PROTECT_MASK;
      end
   end

   // ==========================================
   // Function ownership across ports
   // Claims reach the next port a cycle late; a quick remap may overlap
   logic [NPINS-1:0] use_func;
   logic [NFUNC-1:0] claim_d;
   logic [NFUNC-1:0] fin_d;
   logic [NFUNC-1:0] fin_seen;

   always_comb begin
      claim_d = claim_in_i;
      fin_d = '0;
      fin_seen = '0;
      for (int p = 0; p < NPINS; p++) begin
         // A lower-letter port already owns the signal: this mapping is ignored
         use_func[p] = (mux_q[p] != MUXW'(`GPM_GPIO_FUNC)) &&
                       !claim_in_i[mux_q[p]];
         if (use_func[p]) begin
            claim_d[mux_q[p]] = 1'b1;
            // Lowest pin of this port wins a duplicate in-port mapping
            if (!fin_seen[mux_q[p]]) begin
               fin_d[mux_q[p]] = pad_in_i[p];
               fin_seen[mux_q[p]] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         claim_o <= '0;
         func_in_o <= '0;
      end else begin
         claim_o <= claim_d;
         func_in_o <= fin_d;
      end
   end

   // ==========================================
   // Pad cells
   logic [NPINS-1:0] c_out;
   logic [NPINS-1:0] c_oe;
   logic [NPINS-1:0] c_pu;
   logic [NPINS-1:0] c_pd;
   logic [2:0] c_drv [NPINS];
   logic [NPINS-1:0] c_slew;
   logic [NPINS-1:0] c_ana;
   logic [NPINS-1:0] c_wake;

   for (genvar p = 0; p < NPINS; p++) begin : g_pad
      // Mux selects the source, pad type shapes the pin: both are needed
      gpm_pad u_pad (
         .gpio_out_i(out_q[p]),
         .gpio_dir_i(dir_q[p]),
         .use_func_i(use_func[p]),
         .func_out_i(func_out_i[mux_q[p]]),
         .func_oe_i(func_oe_i[mux_q[p]]),
         .level_i(pad_in_i[p]),
         .drive_i(drive_q[p]),
         .type_i(type_q[p]),
         .out_o(c_out[p]),
         .oe_o(c_oe[p]),
         .pu_o(c_pu[p]),
         .pd_o(c_pd[p]),
         .drive_o(c_drv[p]),
         .slew_o(c_slew[p]),
         .ana_o(c_ana[p]),
         .wake_o(c_wake[p])
      );
   end

   // Pin outputs leave through flops, one cycle behind the settings
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pad_out_o <= '0;
         pad_oe_o <= '0;
         pad_pu_o <= '0;
         pad_pd_o <= '0;
         pad_drive_o <= '0;
         pad_slew_o <= '0;
         pad_ana_o <= '0;
         wake_o <= 1'b0;
      end else begin
         pad_out_o <= c_out;
         pad_oe_o <= c_oe;
         pad_pu_o <= c_pu;
         pad_pd_o <= c_pd;
         for (int p = 0; p < NPINS; p++) begin
            pad_drive_o[p*3 +: 3] <= c_drv[p];
         end
         pad_slew_o <= c_slew;
         pad_ana_o <= c_ana;
         wake_o <= |c_wake;
      end
   end
endmodule

// >>> verif/gpm_port_checker.sv
`timescale 1ns/1ns
`include "gpm_defines.svh"
module gpm_port_checker
   import gpm_pkg::*;
#(
   parameter int NPINS = 8,
   parameter int NFUNC = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [NPINS-1:0] pad_oe_o,
   input wire logic [NPINS-1:0] pad_pu_o,
   input wire logic [NPINS-1:0] pad_pd_o,
   input wire logic [NPINS*3-1:0] pad_drive_o,
   input wire logic [NPINS-1:0] pad_slew_o,
   input wire logic [NPINS-1:0] pad_ana_o,
   input wire logic [NFUNC-1:0] func_in_o,
   input wire logic [NFUNC-1:0] claim_in_i,
   input wire logic [NFUNC-1:0] claim_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_on_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   read_upper_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i &&
      wb_adr_i == `GPM_OFF_DATA |=> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
   pull_excl_a: assert property ((pad_pu_o & pad_pd_o) == '0) else $error("both pulls");
   analog_quiet_a: assert property ((pad_ana_o & (pad_pu_o | pad_pd_o | pad_oe_o)) == '0)
      else $error("analog pin driven");
   claim_keep_a: assert property (1'b1 |=> (claim_o & $past(claim_in_i)) == $past(claim_in_i))
      else $error("claim lost");
   claim_ignore_a: assert property (1'b1 |=> (func_in_o & $past(claim_in_i)) == '0)
      else $error("claimed function routed");
   reset_clear_a: assert property ($fell(rst_i) |-> pad_oe_o == '0 && claim_o == '0)
      else $error("outputs not cleared");
   for (genvar g = 0; g < NPINS; g++) begin : g_pin
      slew_code_a: assert property (pad_slew_o[g] |-> pad_drive_o[3*g+:3] == 3'h3)
         else $error("slew without code");
   end
endmodule

bind gpm_port gpm_port_checker #(.NPINS(NPINS), .NFUNC(NFUNC)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .pad_oe_o(pad_oe_o), .pad_pu_o(pad_pu_o), .pad_pd_o(pad_pd_o),
   .pad_drive_o(pad_drive_o), .pad_slew_o(pad_slew_o), .pad_ana_o(pad_ana_o),
   .func_in_o(func_in_o), .claim_in_i(claim_in_i), .claim_o(claim_o));

// >>> verif/gpm_board.sv
`timescale 1ns/1ns
module gpm_board (
   input wire logic clk_i,
   input wire logic [7:0] out_i,
   input wire logic [7:0] oe_i,
   input wire logic [7:0] pu_i,
   input wire logic [7:0] pd_i,
   output logic [7:0] level_o
);
   // ==========================================
   // Pin levels
   // Floating pins toggle so a stale value never passes for a real one
   logic [7:0] flt_q = 8'h00;
   always @(posedge clk_i) begin
      flt_q <= ~flt_q;
   end
   assign level_o = (oe_i & out_i) | (~oe_i & (pu_i | (~pd_i & flt_q)));
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ns
`include "gpm_defines.svh"
module tb_top;
   import gpm_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, wake;
   logic [7:0] adr = 0, pin, pout, poe, ppu, ppd, pslw, pana, fout = 0, foe = 0;
   logic [7:0] fin, cin = 0, cout;
   logic [3:0] sel = 4'hf;
   logic [31:0] dat = 0, rdat, v, s, ev;
   logic [23:0] pdrv;
   logic [31:0] expq[$];
   int failures = 0, compares = 0;
   integer seed = 32'h9cf0a16f;
   gpm_port dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .pad_in_i(pin), .pad_out_o(pout), .pad_oe_o(poe), .pad_pu_o(ppu), .pad_pd_o(ppd),
      .pad_drive_o(pdrv), .pad_slew_o(pslw), .pad_ana_o(pana), .wake_o(wake),
      .func_out_i(fout), .func_oe_i(foe), .func_in_o(fin), .claim_in_i(cin), .claim_o(cout));
   gpm_board board (.clk_i(clk_i), .out_i(pout), .oe_i(poe), .pu_i(ppu), .pd_i(ppd),
      .level_o(pin));
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   // ==========================================
   // Bus tasks
   task conclude;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      // Idle cycles let pin levels settle through the input path
      repeat (3) @(posedge clk_i);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      cyc <= 0; stb <= 0;
      if (n >= 20) begin
         failures++;
         conclude();
      end
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0 && cyc === 1'b1) begin
         ev = (expq.size() > 0) ? expq.pop_front() : ~rdat;
         compares++;
         if (rdat !== ev) begin
            failures++;
            $display("mismatch t=%0t got %h exp %h", $time, rdat, ev);
         end
      end
   end
   // ==========================================
   // Scenarios
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      rd(`GPM_OFF_LOCK, 32'h1);
      rd(`GPM_OFF_COMMIT, 32'hf0);
      rd(`GPM_OFF_MUX, 32'h0);
      rd(8'h20, 32'h0);
      $display("test reset done");
      wr(`GPM_OFF_SEL, 32'h11);
      wr(`GPM_OFF_PAD, 32'h12);
      wr(`GPM_OFF_COMMIT, 32'hff);
      rd(`GPM_OFF_PAD, 32'h0);
      rd(`GPM_OFF_COMMIT, 32'hf0);
      wr(`GPM_OFF_SEL, 32'h10);
      rd(`GPM_OFF_PAD, 32'h12);
      wr(`GPM_OFF_LOCK, `GPM_UNLOCK_KEY);
      wr(`GPM_OFF_COMMIT, 32'hff);
      wr(`GPM_OFF_SEL, 32'h01);
      wr(`GPM_OFF_PAD, 32'h12);
      rd(`GPM_OFF_PAD, 32'h12);
      wr(`GPM_OFF_LOCK, 32'h0);
      rd(`GPM_OFF_LOCK, 32'h1);
      $display("test lock done");
      wr(`GPM_OFF_SEL, 32'hff);
      wr(`GPM_OFF_DIR, 32'hff);
      repeat (4) begin
         v = $random(seed);
         s = $random(seed);
         wr(`GPM_OFF_DATA, v);
         wr(`GPM_OFF_SEL, s);
         rd(`GPM_OFF_DATA, {24'h0, v[7:0] & s[7:0]});
         wr(`GPM_OFF_SEL, 32'hff);
      end
      $display("test masked read done");
      wr(`GPM_OFF_SEL, 32'h10);
      wr(`GPM_OFF_DIR, 32'h0);
      for (int t = 0; t < 7; t++) begin
         for (int d = 0; d < 7; d++) begin
            wr(`GPM_OFF_PAD, 32'(t * 16 + d));
            @(posedge clk_i);
            chk({27'h0, pdrv[14:12], pslw[4], pana[4]}, (t == 4) ? 32'h1 : 32'h0);
            rd(`GPM_OFF_PAD, 32'(t * 16 + d));
            if (t == 1 || t == 2)
               rd(`GPM_OFF_DATA, (t == 1) ? 32'h10 : 32'h0);
         end
      end
      $display("test pad codes done");
      wr(`GPM_OFF_DIR, 32'h10);
      wr(`GPM_OFF_DATA, 32'h10);
      wr(`GPM_OFF_PAD, 32'h50);
      rd(`GPM_OFF_WAKE, 32'h1);
      wr(`GPM_OFF_PAD, 32'h60);
      rd(`GPM_OFF_WAKE, 32'h0);
      wr(`GPM_OFF_PAD, 32'h03);
      @(posedge clk_i);
      chk({29'h0, pdrv[14:12]}, 32'h3);
      chk({31'h0, pslw[4]}, 32'h1);
      wr(`GPM_OFF_PAD, 32'h06);
      @(posedge clk_i);
      chk({29'h0, pdrv[14:12]}, 32'h6);
      chk({31'h0, pslw[4]}, 32'h0);
      $display("test wake done");
      wr(`GPM_OFF_PAD, 32'h0);
      wr(`GPM_OFF_DATA, 32'h0);
      v = $random(seed);
      fout <= v[7:0] | 8'h04;
      foe <= 8'hff;
      wr(`GPM_OFF_MUX, 32'h2);
      rd(`GPM_OFF_MUX, 32'h2);
      rd(`GPM_OFF_DATA, 32'h10);
      chk({24'h0, fin}, 32'h04);
      chk({24'h0, cout}, 32'h04);
      cin <= 8'h04;
      rd(`GPM_OFF_DATA, 32'h0);
      chk({24'h0, fin}, 32'h0);
      chk({24'h0, cout}, 32'h04);
      $display("test mux done");
      cin <= 8'h00;
      rst_i <= 1;
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      chk({24'h0, poe}, 32'h0);
      wr(`GPM_OFF_SEL, 32'h10);
      rd(`GPM_OFF_MUX, 32'h0);
      rd(`GPM_OFF_LOCK, 32'h1);
      rd(`GPM_OFF_COMMIT, 32'hf0);
      $display("test mid-run reset done");
      conclude();
   end
endmodule
